/* core/fram_host_ctrl.sv */
// Host-side controller for an asynchronous bytewide nonvolatile memory.
// Assumes a pull-up on the select pin and a single 10 MHz clock domain.
`timescale 1ns/100ps
module fram_host_ctrl
   import fram_host_pkg::*;
(
   input  wire logic              clock,
   input  wire logic              rst_b,
   input  wire logic              supplyGood,
   input  wire logic              reqValid,
   output logic                   reqReady,
   input  wire logic              reqWrite,
   input  wire logic [ADDR_W-1:0] reqAddr,
   input  wire logic [DATA_W-1:0] reqWdata,
   output logic                   rdValid,
   output logic      [DATA_W-1:0] rdData,
   output logic                   selectOut_b,
   output logic                   selectOe,
   output logic                   writeEn_b,
   output logic                   outEn_b,
   output logic      [ADDR_W-1:0] addrOut,
   input  wire logic [DATA_W-1:0] dataIn,
   output logic      [DATA_W-1:0] dataOut,
   output logic                   dataOe
);

   // ************************************************************
   // Reset release and input synchronisation
   // ************************************************************
   logic rstSync1_q;
   logic rstSync2_q;
   logic rstInt_b;

   always_ff @(posedge clock or negedge rst_b)
   begin
      if (!rst_b)
      begin
         rstSync1_q <= 1'b0;
         rstSync2_q <= 1'b0;
      end
      else
      begin
         rstSync1_q <= 1'b1;
         rstSync2_q <= rstSync1_q;
      end
   end

   assign rstInt_b = rstSync2_q;

   logic             supplyGoodSync;
   logic [DATA_W-1:0] dataInSync;

   // The supply monitor is asynchronous, so it is treated as low until proven good.
   sync_two_flop #(.WIDTH(1), .INIT(1'b0)) uSupplySync
   (
      .clock (clock),
      .rst_b (rstInt_b),
      .din   (supplyGood),
      .dout  (supplyGoodSync)
   );

   sync_two_flop #(.WIDTH(DATA_W), .INIT('0)) uDataSync
   (
      .clock (clock),
      .rst_b (rstInt_b),
      .din   (dataIn),
      .dout  (dataInSync)
   );

   // ************************************************************
   // Access sequencer
   // ************************************************************
   hostState_t        state_q;
   hostState_t        state_d;
   logic [CNT_W-1:0]  cnt_q;
   logic [CNT_W-1:0]  cnt_d;
   logic              selectLow_q;
   logic              selectLow_d;
   logic              writeLow_q;
   logic              writeLow_d;
   logic              outEnLow_q;
   logic              outEnLow_d;
   logic              dataDrive_q;
   logic              dataDrive_d;
   logic [ADDR_W-1:0] addr_q;
   logic [DATA_W-1:0] wdata_q;
   logic [DATA_W-1:0] rdData_q;
   logic              rdValid_q;
   logic [1:0]        rdPipe_q;
   logic              readEnd;
   logic              cntDone;
   logic              startAccess;
   logic              selOk;

   assign cntDone     = (cnt_q == CNT_ONE);
   assign readEnd     = (state_q == ST_READ) && cntDone;
   assign startAccess = (state_q == ST_IDLE) && reqValid && supplyGoodSync;
   assign reqReady    = (state_q == ST_IDLE) && supplyGoodSync;
   // The write pulse may end only when both its own width and select-to-rise are met.
   assign selOk       = cntDone;

   always_comb
   begin
      state_d     = state_q;
      cnt_d       = cnt_q;
      selectLow_d = selectLow_q;
      writeLow_d  = writeLow_q;
      outEnLow_d  = outEnLow_q;
      dataDrive_d = dataDrive_q;
      case (state_q)
         ST_IDLE:
         begin
            if (startAccess)
            begin
               // A fresh select fall opens every access; on a write, write enable falls and data is driven
               // with it so the cycle starts as a select-controlled write.
               selectLow_d = 1'b1;
               if (reqWrite)
               begin
                  writeLow_d  = 1'b1;
                  dataDrive_d = 1'b1;
                  cnt_d       = CNT_CNT(SEL_TO_WR_CYC, WRITE_LOW_CYC, SELECT_LOW_CYC);
                  state_d     = ST_WRITE;
               end
               else
               begin
                  outEnLow_d = 1'b1;
                  cnt_d      = CNT_CNT(READ_WAIT_CYC, SELECT_LOW_CYC, 1);
                  state_d    = ST_READ;
               end
            end
         end
         ST_READ:
         begin
            if (cntDone)
            begin
               selectLow_d = 1'b0;
               outEnLow_d  = 1'b0;
               cnt_d       = CNT_CNT(PRECHARGE_CYC, 1, 1);
               state_d     = ST_PRECH;
            end
            else
            begin
               cnt_d = cnt_q - CNT_ONE;
            end
         end
         ST_WRITE:
         begin
            if (selOk)
            begin
               // Write enable and select rise together; the device ends the write there.
               writeLow_d  = 1'b0;
               selectLow_d = 1'b0;
               cnt_d       = CNT_CNT(BUS_TURN_CYC, 1, 1);
               state_d     = ST_WEND;
            end
            else
            begin
               cnt_d = cnt_q - CNT_ONE;
            end
         end
         ST_WEND:
         begin
            // Data is held one more cycle past the rising edges (zero hold needed).
            dataDrive_d = 1'b0;
            cnt_d       = CNT_CNT(PRECHARGE_CYC, 1, 1);
            state_d     = ST_PRECH;
         end
         ST_PRECH:
         begin
            if (cntDone)
            begin
               state_d = ST_IDLE;
            end
            else
            begin
               cnt_d = cnt_q - CNT_ONE;
            end
         end
         default:
         begin
            state_d     = ST_IDLE;
            selectLow_d = 1'b0;
            writeLow_d  = 1'b0;
            outEnLow_d  = 1'b0;
            dataDrive_d = 1'b0;
         end
      endcase
   end

   // Largest of three cycle counts, cut to the counter width.
   function automatic logic [CNT_W-1:0] CNT_CNT(input int a, input int b, input int c);
      int m;
      m = (a > b) ? a : b;
      m = (m > c) ? m : c;
      return m[CNT_W-1:0];
   endfunction

   always_ff @(posedge clock or negedge rstInt_b)
   begin
      if (!rstInt_b)
      begin
         state_q     <= ST_IDLE;
         cnt_q       <= '0;
         selectLow_q <= 1'b0;
         writeLow_q  <= 1'b0;
         outEnLow_q  <= 1'b0;
         dataDrive_q <= 1'b0;
      end
      else
      begin
         state_q     <= state_d;
         cnt_q       <= cnt_d;
         selectLow_q <= selectLow_d;
         writeLow_q  <= writeLow_d;
         outEnLow_q  <= outEnLow_d;
         dataDrive_q <= dataDrive_d;
      end
   end

   // ************************************************************
   // Address, write data and read capture
   // ************************************************************
   always_ff @(posedge clock or negedge rstInt_b)
   begin
      if (!rstInt_b)
      begin
         addr_q    <= '0;
         wdata_q   <= '0;
         rdData_q  <= '0;
         rdValid_q <= 1'b0;
         rdPipe_q  <= '0;
      end
      else
      begin
         // Address is held for the whole access even though the device latched it.
         if (startAccess)
         begin
            addr_q  <= reqAddr;
            wdata_q <= reqWdata;
         end
         // The pins are taken at the edge that raises select; the synchroniser
         // needs two more edges before that byte can be stored.
         rdPipe_q  <= {rdPipe_q[0], readEnd};
         rdValid_q <= rdPipe_q[1];
         if (rdPipe_q[1])
         begin
            rdData_q <= dataInSync;
         end
      end
   end

   // ************************************************************
   // Pin drivers
   // ************************************************************
   // Select pin is released during reset so the pull-up tracks the supply.
   assign selectOe    = rstInt_b;
   assign selectOut_b = !selectLow_q;
   assign writeEn_b   = !writeLow_q;
   assign outEn_b     = !outEnLow_q;
   assign addrOut     = addr_q;
   assign dataOut     = wdata_q;
   assign dataOe      = dataDrive_q;
   assign rdData      = rdData_q;
   assign rdValid     = rdValid_q;

endmodule

/* core/fram_host_pkg.sv */
// Constants shared by the bytewide memory host controller.
// Assumes a 10 MHz system clock driving all timing counts.
package fram_host_pkg;

   localparam int CLOCK_PERIOD_NS = 100;
   localparam int ADDR_W = 15;
   localparam int DATA_W = 8;

   // Interface minimum and maximum times in nanoseconds.
   localparam int SELECT_LOW_MIN_NS = 70;
   localparam int PRECHARGE_MIN_NS = 60;
   localparam int SELECT_TO_WRITE_RISE_MIN_NS = 70;
   localparam int WRITE_LOW_MIN_NS = 40;
   localparam int READ_VALID_MAX_NS = 70;
   localparam int OE_ACCESS_MAX_NS = 12;
   localparam int WRITE_RISE_TO_DRIVE_NS = 10;

   // Least times round up to whole cycles, never less than one.
   function automatic int cyclesUp(input int ns);
      int c;
      c = (ns + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
      return (c < 1) ? 1 : c;
   endfunction

   localparam int SELECT_LOW_CYC = cyclesUp(SELECT_LOW_MIN_NS);
   localparam int PRECHARGE_CYC = cyclesUp(PRECHARGE_MIN_NS);
   localparam int SEL_TO_WR_CYC = cyclesUp(SELECT_TO_WRITE_RISE_MIN_NS);
   localparam int WRITE_LOW_CYC = cyclesUp(WRITE_LOW_MIN_NS);
   // Read data is sampled only after both access limits have passed.
   localparam int READ_WAIT_CYC = cyclesUp(READ_VALID_MAX_NS + OE_ACCESS_MAX_NS);
   localparam int BUS_TURN_CYC = cyclesUp(WRITE_RISE_TO_DRIVE_NS);

   localparam int CNT_W = 4;
   localparam logic [CNT_W-1:0] CNT_ONE = 4'h1;

   typedef enum logic [2:0]
   {
      ST_IDLE   = 3'b000,
      ST_READ   = 3'b001,
      ST_WRITE  = 3'b010,
      ST_WEND   = 3'b011,
      ST_PRECH  = 3'b100
   } hostState_t;

endpackage

/* core/sync_two_flop.sv */
// Two flip-flop synchroniser for a bus of levels from outside the clock domain.
// Assumes the input bits are independent or quasi-static while sampled.
`timescale 1ns/100ps
module sync_two_flop
#(
   parameter int WIDTH = 1,
   parameter logic [WIDTH-1:0] INIT = '0
)
(
   input  wire logic             clock,
   input  wire logic             rst_b,
   input  wire logic [WIDTH-1:0] din,
   output logic      [WIDTH-1:0] dout
);

   logic [WIDTH-1:0] meta_q;

   always_ff @(posedge clock or negedge rst_b)
   begin
      if (!rst_b)
      begin
         meta_q <= INIT;
         dout   <= INIT;
      end
      else
      begin
         meta_q <= din;
         dout   <= meta_q;
      end
   end

endmodule

/* bench/fram_host_ctrl_asserts.sv */
// Port checker for the bytewide memory host controller.
// Assumes it is bound into every instance of the controller.
`timescale 1ns/100ps
module fram_host_ctrl_chk
   import fram_host_pkg::*;
(
   input wire logic              clock,
   input wire logic              rst_b,
   input wire logic              supplyGood,
   input wire logic              reqValid,
   input wire logic              reqReady,
   input wire logic              reqWrite,
   input wire logic [ADDR_W-1:0] reqAddr,
   input wire logic [DATA_W-1:0] reqWdata,
   input wire logic              rdValid,
   input wire logic              selectOut_b,
   input wire logic              selectOe,
   input wire logic              writeEn_b,
   input wire logic              outEn_b,
   input wire logic [ADDR_W-1:0] addrOut,
   input wire logic [DATA_W-1:0] dataOut,
   input wire logic              dataOe
);
   // ******
   // Checks
   // ******
   // The select pin level includes the board pull-up while the host lets go.
   wire logic selPin = selectOe ? selectOut_b : 1'b1;
   wire logic takeRd = reqValid && reqReady && !reqWrite;
   wire logic takeWr = reqValid && reqReady && reqWrite;
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_b);
   AST_RESET_FLOAT: assert property (disable iff (1'b0) !rst_b |-> !selectOe && !dataOe && writeEn_b && outEn_b)
      else $error("Host drives pins during reset");
   AST_ONE_LOW: assert property (!selPin |-> !reqReady ##1 selPin)
      else $error("Select held low across accesses");
   AST_PRECHARGE: assert property ($rose(selPin) |-> !reqReady ##1 selPin)
      else $error("Precharge shorter than one cycle");
   AST_SUPPLY_OFF: assert property (!supplyGood [*5] |-> selPin && !reqReady)
      else $error("Access while supply low");
   AST_WRITE_FALL: assert property ($fell(writeEn_b) |-> $fell(selPin) && dataOe ##1 writeEn_b && selPin)
      else $error("Write strobe not tied to select");
   AST_NO_FIGHT: assert property (dataOe |-> outEn_b)
      else $error("Host drives data with output enable low");
   AST_READ_WALK: assert property (takeRd |=> !selPin && !outEn_b && writeEn_b
      && addrOut == $past(reqAddr) ##3 rdValid)
      else $error("Read cycle shape or result timing wrong");
   AST_WRITE_WALK: assert property (takeWr |=> !selPin && !writeEn_b && dataOe
      && dataOut == $past(reqWdata) && addrOut == $past(reqAddr) ##1 selPin && writeEn_b ##1 !dataOe)
      else $error("Write cycle shape wrong");
   COV_READ: cover property (takeRd);
   COV_WRITE_READ: cover property (takeWr ##[1:8] takeRd);
   COV_SUPPLY: cover property ((!supplyGood && reqValid) [*4]);
endmodule

bind fram_host_ctrl fram_host_ctrl_chk i_fram_host_ctrl_chk
(
   .clock, .rst_b, .supplyGood, .reqValid, .reqReady, .reqWrite, .reqAddr, .reqWdata, .rdValid,
   .selectOut_b, .selectOe, .writeEn_b, .outEn_b, .addrOut, .dataOut, .dataOe
);

/* bench/fram_dev_model.sv */
// Behavioural model of the bytewide nonvolatile memory on the host's far side.
// Assumes the bench resolves the select pull-up and the shared data pins.
`timescale 1ns/100ps
module fram_dev_model
   import fram_host_pkg::*;
#(
   parameter int ACC_NS = 70,
   parameter int OE_NS  = 12,
   parameter int WX_NS  = 10
)
(
   input  wire logic              selPin_b,
   input  wire logic              writeEn_b,
   input  wire logic              outEn_b,
   input  wire logic [ADDR_W-1:0] addr,
   input  wire logic [DATA_W-1:0] dataPin,
   output logic      [DATA_W-1:0] memQ,
   output logic                   memOe
);
   // *****
   // Array
   // *****
   logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];
   logic [ADDR_W-1:0] latAddr = '0;
   logic              accDone = 1'b0;
   logic              writing = 1'b0;
   logic              wxBlock = 1'b0;
   // There is no supply monitor, so the model never refuses an access.
   always @(negedge selPin_b)
   begin
      // Address and write enable switch on the same clock edge as select, so let them settle.
      #1;
      latAddr = addr;
      writing = !writeEn_b;
      if (!writing)
         #(ACC_NS) accDone = 1'b1;
   end
   always @(negedge writeEn_b)
      if (!selPin_b)
         writing = 1'b1;
   always @(posedge selPin_b or posedge writeEn_b)
   begin
      if (writing)
         mem[latAddr] = dataPin;
      writing = 1'b0;
      if (selPin_b)
         accDone = 1'b0;
   end
   always @(posedge writeEn_b)
   begin
      wxBlock = 1'b1;
      #(WX_NS) wxBlock = 1'b0;
   end
   assign memQ = mem[latAddr];
   // The inertial delay also slows the release, which stays inside the float limit.
   assign #(OE_NS) memOe = accDone && !selPin_b && !outEn_b && !writing && !wxBlock;
endmodule

/* bench/tb.sv */
// Self-checking bench for the bytewide memory host controller.
// Assumes the device model sits on the pins, with a pull-up on select.
`timescale 1ns/100ps
module tb
   import fram_host_pkg::*;
;
   logic              clock = 1'b0;
   logic              rst_b = 1'b1;
   logic              supplyGood = 1'b0;
   logic              reqValid = 1'b0;
   logic              reqWrite = 1'b0;
   logic [ADDR_W-1:0] reqAddr = '0;
   logic [DATA_W-1:0] reqWdata = '0;
   logic              reqReady, rdValid, selectOut_b, selectOe, writeEn_b, outEn_b, dataOe, memOe;
   logic [ADDR_W-1:0] addrOut, a;
   logic [DATA_W-1:0] rdData, dataOut, memQ, dataPin;
   logic [DATA_W-1:0] shadow [logic [ADDR_W-1:0]];
   logic [DATA_W-1:0] expQ [$];
   int                fails = 0;
   int                samples_checked = 0;
   int                cycles = 0;
   int                seedDummy;
   wire logic         selPin_b = selectOe ? selectOut_b : 1'b1;
   // A released data bus shows a pattern that moves every cycle, never the old byte.
   assign dataPin = dataOe ? dataOut : memOe ? memQ : cycles[DATA_W-1:0];
   always #50 clock = ~clock;
   fram_host_ctrl i_fram_host_ctrl
   (
      .clock, .rst_b, .supplyGood, .reqValid, .reqReady, .reqWrite, .reqAddr, .reqWdata, .rdValid, .rdData,
      .selectOut_b, .selectOe, .writeEn_b, .outEn_b, .addrOut, .dataIn(dataPin), .dataOut, .dataOe
   );
   fram_dev_model i_fram_dev_model
   (
      .selPin_b, .writeEn_b, .outEn_b, .addr(addrOut), .dataPin, .memQ, .memOe
   );
   // *****
   // Tasks
   // *****
   task automatic check(input string what, input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         fails++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic give_verdict();
      if (fails == 0 && samples_checked > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   task automatic access(input logic wr, input logic [ADDR_W-1:0] ad, input logic [DATA_W-1:0] wd);
      int n;
      n = 0;
      @(negedge clock);
      reqValid = 1'b1;
      reqWrite = wr;
      reqAddr = ad;
      reqWdata = wd;
      // Ready comes from flops, so its level at a falling edge holds through the next rising edge.
      while (reqReady !== 1'b1 && n < 40)
      begin
         @(negedge clock);
         n++;
      end
      if (reqReady !== 1'b1)
         check("request taken", 8'h00, 8'h01);
      else if (wr)
         shadow[ad] = wd;
      else
         expQ.push_back(shadow[ad]);
      @(negedge clock);
      reqValid = 1'b0;
      reqAddr = ~ad;
   endtask
   // Outputs are looked at on the falling edge, half a cycle after they settle.
   always @(negedge clock)
   begin
      cycles++;
      if (rdValid === 1'b1)
      begin
         if (expQ.size() == 0)
            check("unexpected read", 8'h00, 8'h01);
         else
            check("read data", rdData, expQ.pop_front());
      end
      if (cycles > 2000)
      begin
         fails++;
         give_verdict();
      end
   end
   // ********
   // Sequence
   // ********
   initial
   begin
      seedDummy = $urandom(54074);
      // Reset is applied off the clock edge so every flop starts from a known level.
      #1;
      rst_b = 1'b0;
      repeat (5) @(negedge clock);
      rst_b = 1'b1;
      repeat (6) @(negedge clock);
      check("ready without supply", DATA_W'(reqReady), 8'h00);
      supplyGood = 1'b1;
      access(1'b1, '0, 8'h5a);
      access(1'b1, '1, 8'ha5);
      repeat (12) access(1'b1, ADDR_W'($urandom), DATA_W'($urandom));
      foreach (shadow[k])
         access(1'b0, k, '0);
      a = ADDR_W'($urandom);
      access(1'b1, a, 8'h3c);
      access(1'b0, a, '0);
      @(negedge clock);
      supplyGood = 1'b0;
      repeat (5) @(negedge clock);
      check("ready on low supply", DATA_W'(reqReady), 8'h00);
      fork
         access(1'b0, a, '0);
         begin
            repeat (8) @(negedge clock);
            check("select on low supply", DATA_W'(selPin_b), 8'h01);
            supplyGood = 1'b1;
         end
      join
      repeat (6) @(negedge clock);
      rst_b = 1'b0;
      @(posedge clock);
      check("select drive in reset", DATA_W'(selectOe), 8'h00);
      check("select pin in reset", DATA_W'(selPin_b), 8'h01);
      @(negedge clock);
      rst_b = 1'b1;
      access(1'b0, '1, '0);
      repeat (8) @(negedge clock);
      check("reads outstanding", DATA_W'(expQ.size()), 8'h00);
      give_verdict();
   end
endmodule
